// ==== src/frame_cfg_pkg.sv ====
// Constants and types shared by the frame configuration controls.
// Operation
// - Uncorrectable code error aborts frame, receiver off.
// - Auto re-enable restarts preamble search after abort.
// - Every uncorrectable code error inside a frame sets event bit.
// - Abort disabled: demodulate to header length.
// - Seed clear: check sequence starts all zeros.
// - Seed set: check sequence starts all ones.
// - Format 00: standard header, 127 octet payload.
// - Format 11: long header, up to 1023 octets.
// - Both nodes need the same header format.
// - Boost on at 6.8M: power by length.
// - Boost off: power set per frame phase.
// - Low rate: long delimiter, 110 kbps mode.
// - Default rate: short delimiter, rate from header.
package frame_cfg_pkg;

    localparam logic [7:0] SYSCFG_OFFSET = 8'h04;
    localparam logic [7:0] EVENT_STATUS_OFFSET = 8'h0f;
    localparam logic [31:0] SYSCFG_RESET = 32'h0000_0000;

    localparam int RS_ABORT_DIS_BIT = 14;
    localparam int FCS_SEED_BIT = 15;
    localparam int HDR_FMT_LSB = 16;
    localparam int BOOST_DIS_BIT = 18;
    localparam int LOW_RATE_BIT = 22;
    localparam int AUTO_REEN_BIT = 29;
    localparam int RS_EVENT_BIT = 16;

    // Writable bits; reserved ranges 21..19 and 27..23 read back as zero.
    localparam logic [31:0] SYSCFG_WMASK = 32'hf047_ffff;

    localparam logic [1:0] HDR_FMT_STD = 2'h0;
    localparam logic [1:0] HDR_FMT_LONG = 2'h3;

    localparam logic [9:0] STD_MAX_LEN = 10'h07f;
    localparam logic [9:0] LONG_MAX_LEN = 10'h3ff;

    localparam logic [15:0] FCS_SEED_ZERO = 16'h0000;
    localparam logic [15:0] FCS_SEED_ONES = 16'hffff;

    // Length thresholds (octets) for the boosted power classes.
    localparam logic [9:0] BOOST_LEN_SHORT = 10'h010;
    localparam logic [9:0] BOOST_LEN_MID = 10'h040;
    localparam logic [9:0] BOOST_LEN_LONG = 10'h080;

    typedef struct packed {
        logic auto_reenable;
        logic low_rate;
        logic boost_dis;
        logic [1:0] hdr_fmt;
        logic fcs_seed_ones;
        logic rs_abort_dis;
    } cfg_s;

    typedef enum logic [1:0] {
        RX_OFF,
        RX_HUNT,
        RX_FRAME
    } rx_state_e;

endpackage

// ==== src/radio_frame_config_controls.sv ====
// Configuration register and the frame controls it steers.
`timescale 1ns/10ps
module radio_frame_config_controls (
    input wire logic mclk_i,
    input wire logic rstn_i,
    // Register port.
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    output logic [31:0] reg_rdata_o,
    // Receiver side.
    input wire logic rx_enable_i,
    input wire logic rx_disable_i,
    input wire logic sfd_found_i,
    input wire logic hdr_valid_i,
    input wire logic [9:0] hdr_len_i,
    input wire logic hdr_rate_6m8_i,
    input wire logic rx_octet_i,
    input wire logic rs_uncorrectable_i,
    output logic rx_on_o,
    output logic rx_in_frame_o,
    output logic rx_abort_o,
    output logic rx_done_o,
    output logic rx_len_error_o,
    output logic rx_long_sfd_o,
    output logic rx_rate_110k_o,
    output logic rx_rate_6m8_o,
    output logic rs_error_event_o,
    // Transmit side.
    input wire logic tx_start_i,
    input wire logic tx_rate_6m8_i,
    input wire logic [9:0] tx_frame_length_i,
    input wire logic [1:0] tx_phase_i,
    input wire logic [31:0] tx_power_table_i,
    output logic [7:0] tx_power_o,
    output logic [15:0] fcs_seed_o,
    output logic [1:0] hdr_format_o,
    output logic [9:0] max_len_o,
    output logic hdr_format_bad_o
);

    // All state sits in the mclk_i domain; inputs are taken as synchronous.
    logic [31:0] syscfg_q;
    logic rs_event_q;
    // Receiver sequence state.
    frame_cfg_pkg::rx_state_e state_q;
    frame_cfg_pkg::rx_state_e state_d;
    logic [9:0] len_q;
    logic [9:0] len_d;
    logic [9:0] cnt_q;
    logic [9:0] cnt_d;
    logic rx_6m8_q;
    logic rx_6m8_d;
    // Registered pulse outputs.
    logic abort_q;
    logic done_q;
    logic len_err_q;
    // Transmit side registers.
    logic [15:0] seed_q;
    logic [7:0] power_q;

    // Decoded configuration fields.
    frame_cfg_pkg::cfg_s cfg;
    assign cfg.auto_reenable = syscfg_q[frame_cfg_pkg::AUTO_REEN_BIT];
    assign cfg.low_rate = syscfg_q[frame_cfg_pkg::LOW_RATE_BIT];
    assign cfg.boost_dis = syscfg_q[frame_cfg_pkg::BOOST_DIS_BIT];
    assign cfg.hdr_fmt = syscfg_q[frame_cfg_pkg::HDR_FMT_LSB +: 2];
    assign cfg.fcs_seed_ones = syscfg_q[frame_cfg_pkg::FCS_SEED_BIT];
    assign cfg.rs_abort_dis = syscfg_q[frame_cfg_pkg::RS_ABORT_DIS_BIT];

    // Register decode.
    wire cfg_sel = reg_addr_i == frame_cfg_pkg::SYSCFG_OFFSET;
    wire evt_sel = reg_addr_i == frame_cfg_pkg::EVENT_STATUS_OFFSET;
    wire cfg_wr = reg_wr_i && cfg_sel;
    wire evt_clr = reg_wr_i && evt_sel && reg_wdata_i[frame_cfg_pkg::RS_EVENT_BIT];

    // Reserved positions are masked off, so a stray one there does no harm.
    wire [31:0] cfg_wval = reg_wdata_i & frame_cfg_pkg::SYSCFG_WMASK;

    // Write one to the event bit to clear it; a zero leaves the event alone.
    wire [31:0] evt_rdata = (32'h0000_0001 << frame_cfg_pkg::RS_EVENT_BIT) & {32{rs_event_q}};

    // Reads are combinational; other addresses return zero.
    assign reg_rdata_o = cfg_sel ? syscfg_q :
        evt_sel ? evt_rdata :
        32'h0000_0000;

    // Only whole-word writes exist; the mask clears the reserved positions.
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            syscfg_q <= frame_cfg_pkg::SYSCFG_RESET;
        end else if (cfg_wr) begin
            syscfg_q <= cfg_wval;
        end
    end

    // Header format decode.
    // Standard format length
    wire fmt_std = cfg.hdr_fmt == frame_cfg_pkg::HDR_FMT_STD;
    wire fmt_long = cfg.hdr_fmt == frame_cfg_pkg::HDR_FMT_LONG;
    wire [9:0] max_len = fmt_long ? frame_cfg_pkg::LONG_MAX_LEN : frame_cfg_pkg::STD_MAX_LEN;
    // Unsupported codes fall back to the standard limit and are flagged.
    // Unsupported format flag
    assign hdr_format_bad_o = !(fmt_std || fmt_long);
    // Format shared with peer
    // Both nodes must agree on the format; the block only exports it.
    assign hdr_format_o = cfg.hdr_fmt;
    assign max_len_o = max_len;

    assign rx_long_sfd_o = cfg.low_rate;
    assign rx_rate_110k_o = cfg.low_rate;
    // The header's rate counts only while the low rate mode is off.
    assign rx_rate_6m8_o = !cfg.low_rate && rx_6m8_q;

    // Receiver sequence.
    wire in_frame = state_q == frame_cfg_pkg::RX_FRAME;
    // Outside frames code error pulses are ignored.
    wire rs_hit = in_frame && rs_uncorrectable_i;
    wire rs_abort = rs_hit && !cfg.rs_abort_dis;
    wire hdr_take = in_frame && hdr_valid_i;
    wire len_over = hdr_len_i > max_len;
    // Length 0 ends the frame on its first octet, like length 1.
    wire octet_last = in_frame && rx_octet_i && (cnt_q + 10'h001 >= len_q) && !rs_abort;
    // After the frame or an abort the receiver either rests or hunts again.
    wire [1:0] rest_state = cfg.auto_reenable ? frame_cfg_pkg::RX_HUNT : frame_cfg_pkg::RX_OFF;

    always_comb begin
        state_d = state_q;
        len_d = len_q;
        cnt_d = cnt_q;
        rx_6m8_d = rx_6m8_q;
        unique case (state_q)
            frame_cfg_pkg::RX_OFF: begin
                if (rx_enable_i) begin
                    state_d = frame_cfg_pkg::RX_HUNT;
                end
            end
            frame_cfg_pkg::RX_HUNT: begin
                if (sfd_found_i) begin
                    state_d = frame_cfg_pkg::RX_FRAME;
                    // Before a header arrives the format's limit bounds the frame.
                    len_d = max_len;
                    cnt_d = 10'h000;
                end
            end
            frame_cfg_pkg::RX_FRAME: begin
                if (rs_abort) begin
                    state_d = frame_cfg_pkg::rx_state_e'(rest_state);
                end else if (hdr_take) begin
                    // Run to header length
                    // A corrupt oversized length is clamped to the format's limit.
                    len_d = len_over ? max_len : hdr_len_i;
                    rx_6m8_d = hdr_rate_6m8_i;
                end else if (rx_octet_i) begin
                    cnt_d = cnt_q + 10'h001;
                    if (octet_last) begin
                        state_d = frame_cfg_pkg::rx_state_e'(rest_state);
                    end
                end
            end
            default: begin
                state_d = frame_cfg_pkg::RX_OFF;
            end
        endcase
        // Disable outranks every other cause, an abort included.
        if (rx_disable_i) begin
            state_d = frame_cfg_pkg::RX_OFF;
        end
    end

    // Registered pulse causes; rx_disable_i suppresses both end pulses.
    wire abort_d = rs_abort && !rx_disable_i;
    wire done_d = octet_last && !hdr_take && !rx_disable_i;
    wire len_err_d = hdr_take && len_over;

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= frame_cfg_pkg::RX_OFF;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            len_q <= 10'h000;
        end else begin
            len_q <= len_d;
        end
    end

    // Counts payload octets of the current frame.
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_q <= 10'h000;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rx_6m8_q <= 1'b0;
        end else begin
            rx_6m8_q <= rx_6m8_d;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            abort_q <= 1'b0;
        end else begin
            abort_q <= abort_d;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            done_q <= 1'b0;
        end else begin
            done_q <= done_d;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            len_err_q <= 1'b0;
        end else begin
            len_err_q <= len_err_d;
        end
    end

    assign rx_on_o = state_q != frame_cfg_pkg::RX_OFF;
    assign rx_in_frame_o = in_frame;
    assign rx_abort_o = abort_q;
    assign rx_done_o = done_q;
    assign rx_len_error_o = len_err_q;

    // Sticky event; a new error in the clearing cycle wins over the clear.
    // Record code error
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rs_event_q <= 1'b0;
        end else begin
            rs_event_q <= rs_hit || (rs_event_q && !evt_clr);
        end
    end
    assign rs_error_event_o = rs_event_q;

    // Check sequence seed is taken at each frame start, both directions.
    // Zero seed
    // Ones seed
    // A receive frame starts when the delimiter is seen while hunting.
    wire rx_frame_start = state_q == frame_cfg_pkg::RX_HUNT && sfd_found_i;
    wire frame_start = tx_start_i || rx_frame_start;
    wire [15:0] seed_sel = cfg.fcs_seed_ones ? frame_cfg_pkg::FCS_SEED_ONES :
        frame_cfg_pkg::FCS_SEED_ZERO;
    // A change of the seed bit in mid-frame takes effect at the next frame.

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            seed_q <= frame_cfg_pkg::FCS_SEED_ZERO;
        end else if (frame_start) begin
            seed_q <= seed_sel;
        end
    end
    assign fcs_seed_o = seed_q;

    // Transmit power. Boosted frames pick one table byte by length class;
    // the host must pace them, since nothing here limits the frame rate.
    // Power by length
    wire boost = !cfg.boost_dis && tx_rate_6m8_i;
    // Shorter boosted frames get the stronger table entries.
    wire len_lt_short = tx_frame_length_i < frame_cfg_pkg::BOOST_LEN_SHORT;
    wire len_lt_mid = tx_frame_length_i < frame_cfg_pkg::BOOST_LEN_MID;
    wire len_lt_long = tx_frame_length_i < frame_cfg_pkg::BOOST_LEN_LONG;
    wire [1:0] len_class = len_lt_short ? 2'h3 :
        len_lt_mid ? 2'h2 :
        len_lt_long ? 2'h1 : 2'h0;
    // Outside boost the phase input picks the byte directly.
    // Power per phase
    wire [1:0] pwr_idx = boost ? len_class : tx_phase_i;
    wire [7:0] pwr_sel = tx_power_table_i[{pwr_idx, 3'h0} +: 8];

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            power_q <= 8'h00;
        end else begin
            power_q <= pwr_sel;
        end
    end
    assign tx_power_o = power_q;

endmodule // radio_frame_config_controls

// ==== tb/frame_cfg_assertions.sv ====
// Port assertions for the frame configuration controls.
`timescale 1ns/10ps
module frame_cfg_chk (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic rx_disable_i,
    input wire logic rs_uncorrectable_i,
    input wire logic rx_in_frame_o,
    input wire logic rx_abort_o,
    input wire logic rx_done_o,
    input wire logic rs_error_event_o,
    input wire logic rx_rate_110k_o,
    input wire logic rx_long_sfd_o,
    input wire logic rx_rate_6m8_o,
    input wire logic tx_rate_6m8_i,
    input wire logic [1:0] tx_phase_i,
    input wire logic [31:0] tx_power_table_i,
    input wire logic [7:0] tx_power_o,
    input wire logic [1:0] hdr_format_o,
    input wire logic [9:0] max_len_o,
    input wire logic hdr_format_bad_o
);
    logic [7:0] phase_byte;
    logic rs_hit;
    logic ev_clr;
    assign phase_byte = tx_power_table_i[8*tx_phase_i +: 8];
    assign rs_hit = rx_in_frame_o & rs_uncorrectable_i & ~rx_disable_i;
    assign ev_clr = reg_wr_i & (reg_addr_i == 8'h0f) & reg_wdata_i[16];
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    sequence s_rs_err;
        rs_hit;
    endsequence
    a_rs_event_set: assert property (s_rs_err |=> rs_error_event_o)
        else $error("rs event missing");
    a_rs_event_held: assert property (rs_error_event_o && !ev_clr |=> rs_error_event_o)
        else $error("rs event dropped");
    a_abort_cause: assert property (rx_abort_o |-> $past(rs_hit) && !rx_in_frame_o)
        else $error("abort without cause");
    a_done_ends: assert property (rx_done_o |-> !rx_in_frame_o)
        else $error("frame open after done");
    a_std_len: assert property (hdr_format_o != 2'h3 |-> max_len_o == 10'h07f)
        else $error("standard length wrong");
    a_long_len: assert property (hdr_format_o == 2'h3 |-> max_len_o == 10'h3ff)
        else $error("long length wrong");
    a_fmt_flag: assert property (hdr_format_bad_o == ^hdr_format_o)
        else $error("format flag wrong");
    a_low_rate: assert property (rx_rate_110k_o |-> rx_long_sfd_o && !rx_rate_6m8_o)
        else $error("low rate mode wrong");
    a_phase_power: assert property (!tx_rate_6m8_i |=> tx_power_o == $past(phase_byte))
        else $error("phase power wrong");
endmodule // frame_cfg_chk
bind radio_frame_config_controls frame_cfg_chk frame_cfg_chk_inst (.*);

// ==== tb/peer_node_model.sv ====
// Peer node that sends one frame per go pulse.
`timescale 1ns/10ps
module peer_node_model (
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic slow_i,
    input wire logic [9:0] len_i,
    output logic sfd_o,
    output logic hdr_o,
    output logic [9:0] len_o,
    output logic octet_o
);
    int step = 0;
    logic [9:0] sent;
    logic hold = 1'h0;
    initial len_o = 10'h000;
    always @(posedge clk_i) begin
        hold <= slow_i & ~hold;
        sfd_o <= step == 1;
        hdr_o <= step == 2;
        // same header format.
        // Outside the header the length lines toggle so stale values cannot pass.
        len_o <= (step == 2) ? len_i : ~len_o;
        octet_o <= step == 3 && !hold;
        if (go_i) begin
            step <= 1;
        end else if (step == 1 || step == 2) begin
            step <= step + 1;
        end else if (step == 3 && !hold && sent + 10'h001 == len_i) begin
            step <= 0;
        end
        sent <= (step == 3) ? sent + {9'h000, !hold} : 10'h000;
    end
endmodule // peer_node_model

// ==== tb/radio_frame_config_controls_tb.sv ====
// Self-checking bench for the frame configuration controls.
`timescale 1ns/10ps
module radio_frame_config_controls_tb;
    typedef struct packed {
        logic [31:0] cfg;
        logic rate;
        logic [9:0] len;
        logic [1:0] ph;
        logic [1:0] k;
    } row_s;
    row_s rows [12] = '{'{32'h0004_0000, 1'h1, 10'h005, 2'h0, 2'h0},
        '{32'h0004_0000, 1'h1, 10'h005, 2'h1, 2'h1}, '{32'h0004_0000, 1'h1, 10'h005, 2'h2, 2'h2},
        '{32'h0004_0000, 1'h1, 10'h005, 2'h3, 2'h3}, '{32'h0000_8000, 1'h1, 10'h00f, 2'h0, 2'h3},
        '{32'h0000_8000, 1'h1, 10'h010, 2'h0, 2'h2}, '{32'h0000_8000, 1'h1, 10'h03f, 2'h0, 2'h2},
        '{32'h0000_8000, 1'h1, 10'h040, 2'h0, 2'h1}, '{32'h0000_8000, 1'h1, 10'h07f, 2'h0, 2'h1},
        '{32'h0000_8000, 1'h1, 10'h080, 2'h0, 2'h0}, '{32'hffff_ffff, 1'h0, 10'h080, 2'h2, 2'h2},
        '{32'h0001_8000, 1'h0, 10'h080, 2'h1, 2'h1}};
    logic mclk_i = 1'h0, rstn_i = 1'h0, reg_wr_i = 1'h0, rx_enable_i = 1'h0, rx_disable_i = 1'h0;
    logic rs_uncorrectable_i = 1'h0, tx_start_i = 1'h0, tx_rate_6m8_i = 1'h0, go = 1'h0;
    logic slow = 1'h0, hdr_rate_6m8_i = 1'h1, sfd_found_i, hdr_valid_i, rx_octet_i, rx_on_o;
    logic rx_in_frame_o, rx_abort_o, rx_done_o, rx_len_error_o, rx_long_sfd_o, rx_rate_110k_o;
    logic rx_rate_6m8_o, rs_error_event_o, hdr_format_bad_o;
    logic [7:0] reg_addr_i = 8'h00, tx_power_o;
    logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, tx_power_table_i = 32'h4433_2211, c;
    logic [9:0] hdr_len_i, tx_frame_length_i = 10'h000, max_len_o, flen = 10'h004;
    logic [1:0] tx_phase_i = 2'h0, hdr_format_o;
    logic [15:0] fcs_seed_o;
    int errors = 0, samples_checked = 0, i, j;
    radio_frame_config_controls radio_frame_config_controls_inst (.*);
    peer_node_model peer_node_model_inst (.clk_i(mclk_i), .go_i(go), .slow_i(slow),
        .len_i(flen), .sfd_o(sfd_found_i), .hdr_o(hdr_valid_i), .len_o(hdr_len_i),
        .octet_o(rx_octet_i));
    always #4 mclk_i = ~mclk_i;
    task automatic tick();
        @(posedge mclk_i);
        #1;
    endtask
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        reg_wr_i = 1'h1;
        reg_addr_i = a;
        reg_wdata_i = d;
        tick();
        reg_wr_i = 1'h0;
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic bound();
        if (j >= 40) begin
            errors++;
            summarize();
        end
    endtask
    initial begin
        repeat (12) @(posedge mclk_i);
        #1 rstn_i = 1'h1;
        foreach (rows[r]) begin
            wr(8'h04, rows[r].cfg);
            tx_rate_6m8_i = rows[r].rate;
            tx_frame_length_i = rows[r].len;
            tx_phase_i = rows[r].ph;
            // Pacing boosted frames is the host's duty and is not checked; power, seed and register outputs are.
            tx_start_i = 1'h1;
            tick();
            tx_start_i = 1'h0;
            chk("power", tx_power_o, tx_power_table_i[8*rows[r].k +: 8]);
            chk("seed", fcs_seed_o, {16{rows[r].cfg[15]}});
            chk("cfg", reg_rdata_o, rows[r].cfg & frame_cfg_pkg::SYSCFG_WMASK);
            chk("maxlen", max_len_o, (&rows[r].cfg[17:16]) ? 32'h3ff : 32'h07f);
            chk("fmtbad", hdr_format_bad_o, ^rows[r].cfg[17:16]);
            chk("lowrate", rx_long_sfd_o, rows[r].cfg[22]);
            chk("rate110k", rx_rate_110k_o, rows[r].cfg[22]);
            chk("fmt", hdr_format_o, rows[r].cfg[17:16]);
        end
        for (i = 0; i < 3; i++) begin
            c = (i == 1) ? 32'h2000_0000 : ((i == 2) ? 32'h0000_4000 : 32'h0);
            wr(8'h04, c);
            rx_enable_i = 1'h1;
            go = 1'h1;
            slow = i[1];
            tick();
            rx_enable_i = 1'h0;
            go = 1'h0;
            for (j = 0; j < 40 && rx_octet_i !== 1'h1; j++) tick();
            bound();
            rs_uncorrectable_i = 1'h1;
            tick();
            rs_uncorrectable_i = 1'h0;
            chk("abort", rx_abort_o, !c[14]);
            chk("rx_on", rx_on_o, c[29] | c[14]);
            chk("rate", rx_rate_6m8_o, 1'h1);
            chk("event", rs_error_event_o, 1'h1);
            for (j = 0; c[14] && j < 40 && rx_done_o !== 1'h1; j++) tick();
            bound();
            chk("done", rx_done_o, c[14]);
            wr(8'h0f, 32'h0001_0000);
            chk("clear", reg_rdata_o, 32'h0);
        end
        // Oversized header length under the standard format: flagged while the frame stays open.
        flen = 10'h0ff;
        slow = 1'h0;
        rx_enable_i = 1'h1;
        go = 1'h1;
        tick();
        rx_enable_i = 1'h0;
        go = 1'h0;
        for (j = 0; j < 40 && rx_octet_i !== 1'h1; j++) tick();
        bound();
        chk("lenerr", rx_len_error_o, 1'h1);
        chk("inframe", rx_in_frame_o, 1'h1);
        rx_disable_i = 1'h1;
        tick();
        rx_disable_i = 1'h0;
        chk("rx_off", rx_on_o, 1'h0);
        wr(8'h05, 32'hffff_ffff);
        chk("unmapped", reg_rdata_o, 32'h0);
        wr(8'h04, 32'h0003_8000);
        tx_start_i = 1'h1;
        tick();
        rstn_i = 1'h0;
        tx_start_i = 1'h0;
        tick();
        rstn_i = 1'h1;
        reg_addr_i = 8'h04;
        chk("rst_cfg", reg_rdata_o, frame_cfg_pkg::SYSCFG_RESET);
        chk("rst_seed", fcs_seed_o, 32'h0);
        chk("rst_len", max_len_o, 32'h07f);
        summarize();
    end
endmodule // radio_frame_config_controls_tb
